/* File: rtl/mhbp_host.v */
// Purpose: Host controller driving the transceiver's multiplexed parallel port.
// Assumes: Split-strobe or data-strobe style selected by bus_style; 25 MHz clock.
// Notes: One access at a time; irq_n from the device is synchronised first.
//        PHASE_CYC may not exceed 16, the reach of the phase counter.
`timescale 1ns/1ps
`include "mhbp_consts.vh"

// Function
// R01: Split style: host pulls read strobe low to read a register.
// R02: Data-strobe style: strobe low while data on bus; valid at rising edge.
// R03: Split style: host pulls write strobe low to write a register.
// R04: Data-strobe style: direction high means read, low means write.
// R05: Host holds chip select low for the whole access.
// R06: Chip select picks one of several transceivers; only it responds.
// R07: Device asserts interrupt when status bits change state.
// R08: Device asserts interrupt on elastic store overflow or underflow.
// R09: Host reads performance status register to identify interrupt source.
// R10: Writing one to clear register bit clears and masks that interrupt.
// R11: Writing zero to clear register bit re-enables that interrupt.
// R12: Interrupt is open drain, pulled low only when asserted.
// R13: Address and data share eight bidirectional bus lines.
// R14: Host drives address latch or strobe to mark the address phase.
// R15: A floating address latch/strobe input tristates all device outputs. The device model gates only its bus drive (boe); irq_n stays driven.
// R16: All device control goes through the 8-bit processor port.
// R17: Device captures address at end of address strobe phase.
// R18: Device drives bus only during a selected read data phase.
module mhbp_host #(
    parameter NDEV = 1,
    parameter PHASE_CYC = `MHBP_PHASE_CYC
) (
    input wire ref_clk,
    input wire rst_n,
    input wire bus_style,
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [7:0] req_addr,
    input wire [7:0] req_wdata,
    input wire [NDEV-1:0] req_sel,
    output wire [7:0] rsp_rdata,
    output wire rsp_valid,
    input wire irq_clr_valid,
    input wire [7:0] irq_clr_mask,
    output wire irq_pending,
    output wire [NDEV-1:0] cs_n,
    output wire ale,
    output wire rd_n,
    output wire wr_n,
    output wire [7:0] mux_bus_out,
    output wire mux_bus_oe,
    input wire [7:0] mux_bus_in,
    input wire irq_n
);
    localparam ST_IDLE = 5'h01;
    localparam ST_ADDR = 5'h02;
    localparam ST_GAP = 5'h04;
    localparam ST_DATA = 5'h08;
    localparam ST_END = 5'h10;

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [7:0] wdata_r;
    reg write_r;
    reg style_r;
    reg [NDEV-1:0] sel_r;
    reg irq_s1_r;
    reg irq_s2_r;
    reg [7:0] rd_samp_r;
    reg [7:0] rsp_rdata_r;
    reg rsp_valid_r;
    reg [7:0] bus_out_r;
    reg [7:0] bus_out_nxt;
    wire last_tick;
    genvar gi;
    wire tick;
    wire busy;
    wire take;
    wire clr_take;

    // One phase counter paces every bus phase. It is cleared while the port is
    // idle, so the first phase of an access is never cut short by a stale count.
    mhbp_tick #(
        .DIV(PHASE_CYC)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(busy),
        .tick(tick)
    );

    assign busy = (state_r != ST_IDLE);
    assign req_ready = !busy;
    // A clear-register write request takes precedence over a plain request.
    assign clr_take = !busy && irq_clr_valid; // R10 R11
    assign take = !busy && req_valid && !irq_clr_valid;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (take || clr_take) state_nxt = ST_ADDR;
            ST_ADDR: if (tick) state_nxt = ST_GAP;
            ST_GAP: if (tick) state_nxt = ST_DATA;
            ST_DATA: if (tick) state_nxt = ST_END;
            ST_END: if (tick) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            wdata_r <= 8'h00;
            write_r <= 1'b0;
            style_r <= `MHBP_STYLE_SPLIT;
            sel_r <= {NDEV{1'b0}};
        end else begin
            state_r <= state_nxt;
            // Style and select are latched at take, so a change on either input
            // cannot bend an access that is already under way.
            if (clr_take) begin
                wdata_r <= irq_clr_mask;
                write_r <= 1'b1;
                style_r <= bus_style;
                sel_r <= req_sel; // R06
            end else if (take) begin
                wdata_r <= req_wdata;
                write_r <= req_write;
                style_r <= bus_style;
                sel_r <= req_sel; // R06
            end
        end
    end

    // Read data is taken in the last cycle of the strobe rather than at its
    // rising edge: the device may let go of the bus as the strobe rises.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_samp_r <= 8'h00;
        end else if (state_r == ST_DATA && tick && !write_r) begin
            rd_samp_r <= mux_bus_in; // R02 R09
        end
    end

    assign last_tick = (state_r == ST_END) && tick;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= 8'h00;
        end else begin
            rsp_valid_r <= last_tick;
            if (last_tick) begin
                // Writes answer with zero so a stale read byte never leaks out.
                rsp_rdata_r <= write_r ? 8'h00 : rd_samp_r;
            end
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_rdata_r;

    // The device interrupt is an asynchronous pin: two flops before any use.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
        end else begin
            irq_s1_r <= ~irq_n; // R12
            irq_s2_r <= irq_s1_r;
        end
    end

    // Address and write data come from a flop, so the shared bus never shows a
    // combinational glitch while the host drives it.
    always @* begin
        bus_out_nxt = bus_out_r;
        if (clr_take) begin
            bus_out_nxt = `MHBP_ICR_ADDR; // R10 R11
        end else if (take) begin
            bus_out_nxt = req_addr; // R16
        end else if (state_r == ST_ADDR && tick) begin
            bus_out_nxt = wdata_r;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_out_r <= 8'h00;
        end else begin
            bus_out_r <= bus_out_nxt;
        end
    end

    // Chip select stays low from address phase through end of access. Only the
    // transceiver picked at take time is selected, so the others keep their
    // bus pins released throughout.
    generate
        for (gi = 0; gi < NDEV; gi = gi + 1) begin : g_cs
            assign cs_n[gi] = !(busy && sel_r[gi]); // R05 R06
        end
    endgenerate
    // Address marker: high during address phase in both styles; the device
    // latches on its falling edge.
    assign ale = (state_r == ST_ADDR); // R14 R17
    // Split style: rd_n and wr_n are strobes. Data-strobe style: rd_n is the
    // data strobe and wr_n carries direction (high read, low write).
    assign rd_n = (style_r == `MHBP_STYLE_SPLIT) ?
        !((state_r == ST_DATA) && !write_r) : // R01
        !(state_r == ST_DATA); // R02
    assign wr_n = (style_r == `MHBP_STYLE_SPLIT) ?
        !((state_r == ST_DATA) && write_r) : // R03
        (busy ? !write_r : 1'b1); // R04
    // Host drives the shared bus for the address and for write data only,
    // so it never fights the device in a read data phase.
    assign mux_bus_out = bus_out_r; // R13
    assign mux_bus_oe = (state_r == ST_ADDR) || // R18
        (write_r && (state_r == ST_GAP || state_r == ST_DATA || state_r == ST_END));
    // Pending follows the line two cycles late; the host must still read the
    // status register to learn which event raised it.
    assign irq_pending = irq_s2_r; // R07 R08
endmodule

/* File: rtl/mhbp_consts.vh */
// Purpose: Shared constants for the multiplexed host bus port controller.
// Assumes: 25 MHz ref_clk; device registers reached over an 8-bit muxed bus.
// Notes: Timing figures are in ns; cycle counts derive from them.
`ifndef MHBP_CONSTS_VH
`define MHBP_CONSTS_VH
`define MHBP_CLK_NS 40
`define MHBP_PHASE_NS 80
`define MHBP_PHASE_CYC ((`MHBP_PHASE_NS + `MHBP_CLK_NS - 1) / `MHBP_CLK_NS)
`define MHBP_CNT_W 4
`define MHBP_STYLE_SPLIT 1'b0
`define MHBP_STYLE_DSTRB 1'b1
`define MHBP_PSR_ADDR 8'h00
`define MHBP_ICR_ADDR 8'h01
`define MHBP_BIT_NO_SIGNAL 0
`define MHBP_BIT_ALL_ONES 1
`define MHBP_BIT_TEST_PAT 2
`define MHBP_BIT_DRV_SHORT 3
`define MHBP_BIT_DRV_OPEN 4
`define MHBP_BIT_ES_OVR 5
`define MHBP_BIT_ES_UNF 6
`endif

/* File: rtl/mhbp_tick.v */
// Purpose: Enable pulse divider setting the pace of bus phases.
// Assumes: One clock; rst_n asynchronous active low.
// Notes: tick pulses one cycle every DIV cycles.
`timescale 1ns/1ps
`include "mhbp_consts.vh"
module mhbp_tick #(
    parameter DIV = 2
) (
    input wire ref_clk,
    input wire rst_n,
    input wire run,
    output wire tick
);
    reg [`MHBP_CNT_W-1:0] cnt_r;
    wire [`MHBP_CNT_W-1:0] cnt_nxt;

    localparam integer LAST_I = DIV - 1;
    localparam [`MHBP_CNT_W-1:0] LAST = LAST_I[`MHBP_CNT_W-1:0];

    // Counter restarts while idle so every phase gets its full length.
    assign tick = run && (cnt_r == LAST);
    assign cnt_nxt = (!run || tick) ? {`MHBP_CNT_W{1'b0}} : cnt_r + 1'b1;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {`MHBP_CNT_W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* File: testbench/mhbp_host_assertions.sv */
// Purpose: Port timing checks for mhbp_host.
// Assumes: PHASE_CYC left at 2.
// Notes: Answer delay fixed at 9.
`timescale 1ns/1ps
module mhbp_host_chk #(parameter NDEV = 1) (
    input wire ref_clk,
    input wire rst_n,
    input wire bus_style,
    input wire req_valid,
    input wire req_ready,
    input wire req_write,
    input wire [7:0] req_addr,
    input wire rsp_valid,
    input wire irq_clr_valid,
    input wire irq_pending,
    input wire [NDEV-1:0] cs_n,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire [7:0] mux_bus_out,
    input wire mux_bus_oe,
    input wire irq_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_CS: assert property ((ale || !rd_n || !wr_n) |-> !(&cs_n)) else $error("cs");
    AST_ADR: assert property (req_ready && req_valid && !irq_clr_valid |=>
        ale && mux_bus_oe && mux_bus_out == $past(req_addr)) else $error("addr");
    AST_CLR: assert property (req_ready && irq_clr_valid |=> mux_bus_out == 8'h01)
        else $error("clr");
    AST_RSP: assert property (req_ready && (req_valid || irq_clr_valid) |-> ##9 rsp_valid)
        else $error("rsp");
    AST_RD: assert property (!rd_n && wr_n |-> !mux_bus_oe) else $error("rd");
    AST_WR: assert property (!wr_n && !ale && (!rd_n || !bus_style) |-> mux_bus_oe)
        else $error("wr");
    AST_DIR: assert property (!rd_n |-> $stable(wr_n)) else $error("dir");
    AST_RW: assert property (bus_style && req_ready && req_valid && !irq_clr_valid |=>
        wr_n == !$past(req_write)) else $error("direction value");
    AST_IRQ: assert property (!irq_n [*4] |=> irq_pending) else $error("irq");
endmodule
bind mhbp_host mhbp_host_chk #(.NDEV(NDEV)) u_chk (.*);

/* File: testbench/mhbp_dev.sv */
// Purpose: Device model with status and clear registers.
// Assumes: Tb bus settles 2 ns after strobes.
// Notes: Odd address is the clear register.
`timescale 1ns/1ps
module mhbp_dev (
    input wire cs_n,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire sty,
    input wire [7:0] bi,
    input wire [7:0] ev,
    output wire [7:0] bo,
    output wire boe,
    output wire irq_n
);
    reg [7:0] a_r = 8'h00, icr_r = 8'h00, psr_r = 8'h00, pend_r = 8'h00;
    assign boe = !cs_n && !rd_n && wr_n && !$isunknown(ale);
    assign bo = a_r[0] ? icr_r : psr_r;
    assign irq_n = (|pend_r) ? 1'b0 : 1'b1;
    always @(negedge ale) if (!cs_n) a_r <= bi;
    wire wstb = sty ? rd_n : wr_n;
    // One process owns the pending bits; events never change during an access.
    always @(posedge wstb or ev) begin
        if (!$isunknown(ev)) begin
            pend_r = pend_r | ((ev ^ psr_r) & ~icr_r);
            psr_r = ev;
        end
        if (wstb && !cs_n && (!sty || !wr_n) && a_r[0]) begin
            pend_r = pend_r & ~bi;
            icr_r = bi;
        end
    end
endmodule

/* File: testbench/mhbp_host_tb.sv */
// Purpose: Random tests of mhbp_host with a device model.
// Assumes: NDEV 1, default PHASE_CYC.
// Notes: Idle bus shows the inverse of its last value.
`timescale 1ns/1ps
module mhbp_host_tb;
    reg ref_clk, rst_n, bus_style, req_valid, req_write, irq_clr_valid;
    reg [7:0] req_addr, req_wdata, irq_clr_mask, ev, last_r, m, e;
    wire [7:0] rsp_rdata, mux_bus_out, bo, bus;
    wire req_ready, rsp_valid, irq_pending, cs_n, ale, rd_n, wr_n, mux_bus_oe, boe, irq_n;
    int fail_count = 0, n_compared = 0;
    assign #2 bus = mux_bus_oe ? mux_bus_out : boe ? bo : ~last_r;
    always @(posedge ref_clk) last_r <= bus;
    mhbp_host dut (.*, .mux_bus_in(bus), .req_sel(1'b1));
    mhbp_dev u_dev (.*, .sty(bus_style), .bi(bus));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_irq(input logic [7:0] mask);
        return {7'h00, mask != 8'hff};
    endfunction
    task finish_test;
        $display("compared %0d, wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task io(input logic c, input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {irq_clr_valid, req_valid, req_write, req_addr, req_wdata, irq_clr_mask} <= {c, !c, w, a, d, d};
        @(posedge ref_clk);
        {irq_clr_valid, req_valid} <= 2'b00;
        repeat (12) begin
            @(posedge ref_clk);
            #1;
            if (rsp_valid === 1'b1) break;
        end
        chk({7'h00, rsp_valid}, 8'h01);
    endtask
    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        fail_count++;
        finish_test;
    end
    initial begin
        {rst_n, bus_style, req_valid, req_write, irq_clr_valid} = 5'h00;
        {req_addr, req_wdata, irq_clr_mask, ev, last_r} = 40'h00;
        m = $urandom(32'hf6c3);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1;
        for (int s = 0; s < 8; s++) begin
            bus_style <= s[2];
            m = $urandom;
            e = $urandom;
            if (s < 2) m = s[0] ? 8'h00 : 8'hff;
            io(1, 1, 8'h00, 8'hff);
            @(posedge ref_clk) ev <= e;
            repeat (6) @(posedge ref_clk);
            chk({7'h00, irq_pending}, 8'h00);
            io(0, 1, 8'h01, m);
            @(posedge ref_clk) ev <= ~e;
            repeat (6) @(posedge ref_clk);
            chk({7'h00, irq_pending}, exp_irq(m));
            io(0, 0, 8'h00, 8'h00);
            chk(rsp_rdata, ~e);
            io(0, 0, 8'h01, 8'h00);
            chk(rsp_rdata, m);
        end
        finish_test;
    end
endmodule
